// [pkg/isv_pkg.sv]
// Constants shared by the interrupt vector and stacking block
`default_nettype none
package isv_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_EXT_CTRL = 8'h00;
    localparam logic [7:0] OFS_MASK = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_STACK_PTR = 8'h0c;
    localparam logic [7:0] OFS_PC_VIEW = 8'h10;
    // ext_request_status_ctrl field positions
    localparam int B_PIN_ENABLE = 0;
    localparam int B_POLARITY = 1;
    localparam int B_LEVEL_MODE = 2;
    localparam int B_INT_ENABLE = 3;
    localparam int B_PULL_DISABLE = 4;
    localparam int B_FLAG = 5;
    localparam int B_PIN_LEVEL = 6;
    // Status register field positions
    localparam int B_REQ_VALID = 8;
    localparam int B_SEQ_BUSY = 9;
    // Interrupt mask position inside condition_code_reg
    localparam int B_CCR_MASK = 3;
    // Reset values
    localparam logic [15:0] SP_RESET = 16'h00ff;
    localparam logic [4:0] EXT_CTRL_RESET = 5'h00;
    // Source flag/enable bit indices
    localparam int S_ACMP = 0;
    localparam int S_MTIM = 1;
    localparam int S_RTC = 2;
    localparam int S_IIC = 3;
    localparam int S_ADC = 4;
    localparam int S_PORTB = 5;
    localparam int S_PORTA = 6;
    localparam int S_TX_EMPTY = 7;
    localparam int S_TX_DONE = 8;
    localparam int S_RX_FIRST = 9;
    localparam int S_RX_LAST = 12;
    localparam int S_ERR_FIRST = 13;
    localparam int S_ERR_LAST = 16;
    localparam int S_SYNC_DONE = 17;
    localparam int S_SYNC_FAULT = 18;
    localparam int S_SYNC_TX = 19;
    localparam int NUM_SRC = 20;
    // Vector numbers
    localparam int V_ACMP = 30;
    localparam int V_MTIM = 26;
    localparam int V_RTC = 25;
    localparam int V_IIC = 24;
    localparam int V_ADC = 23;
    localparam int V_PORTB = 21;
    localparam int V_PORTA = 20;
    localparam int V_SCI_TX = 18;
    localparam int V_SCI_RX = 17;
    localparam int V_SCI_ERR = 16;
    localparam int V_SYNC = 15;
    localparam int V_EXT_REQ = 2;
    localparam logic [15:0] VEC_BASE = 16'hffc0;
    localparam logic [4:0] VEC_LAST = 5'd31;
    // Sequence lengths
    localparam logic [2:0] FRAME_BYTES = 3'd5;
    localparam logic [2:0] QUEUE_BYTES = 3'd3;
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_PUSH = 5'b00010,
        ST_VEC = 5'b00100,
        ST_FETCH = 5'b01000,
        ST_POP = 5'b10000
    } isv_state_type;
endpackage
`default_nettype wire

// [rtl/isv_core.sv]
// Interrupt arbitration, external request pin and stack frame sequencer
`default_nettype none
// What this block does
// - Push PC low, PC high, X, A, CONDITION_CODE_REG
// - Stack pointer ends below saved CONDITION_CODE_REG byte
// - Saved PC is next instruction address
// - Index high byte never stacked
// - Return pops reverse order, fetches three bytes
// - Pin is request input only when enabled
// - Polarity, level mode, interrupt-or-poll settings
// - Internal pull follows polarity unless disabled
// - Clocked sampling; async wake in stop
// - Level mode holds flag while asserted
// - Branch level test sees pin level
// - Vector high byte at lower address
// - Flag, local enable, global mask gate requests
// - Finish instruction, stack, mask, fetch vector
// - Lower vector number wins arbitration
// - Comparator on vector 30; 31,29-27 unused
// - Modulo timer 26, real-time tick 25
// - Two-wire 24, converter 23, 22 unused
// - Port B 21, port A 20, 19 unused
// - Async serial: transmit 18, receive 17, errors 16
// - Reset sets the global mask
// - External request pin uses vector 2
module isv_core (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [31:0] HRDATA,
    input wire logic EXT_REQ_PIN,
    input wire logic STOP_MODE,
    output logic EXT_REQ_PULL_UP,
    output logic EXT_REQ_PULL_DOWN,
    output logic EXT_REQ_WAKE,
    output logic EXT_REQ_LEVEL,
    input wire logic [19:0] SRC_FLAGS,
    input wire logic [19:0] SRC_ENABLES,
    input wire logic CPU_INSTR_DONE,
    input wire logic CPU_RETURN,
    input wire logic [15:0] CPU_PC_NEXT,
    input wire logic [7:0] CPU_X,
    input wire logic [7:0] CPU_A,
    input wire logic [7:0] CPU_CCR,
    output logic [15:0] MEM_ADDR,
    output logic [7:0] MEM_WDATA,
    output logic MEM_WE,
    output logic MEM_RE,
    input wire logic [7:0] MEM_RDATA,
    output logic [15:0] CPU_PC_OUT,
    output logic [7:0] CPU_X_OUT,
    output logic [7:0] CPU_A_OUT,
    output logic [7:0] CPU_CCR_OUT,
    output logic [23:0] CPU_QUEUE,
    output logic CPU_RESUME,
    output logic CPU_BUSY
);
    isv_pkg::isv_state_type state_q;
    logic [2:0] cnt_q;
    logic [15:0] sp_q;
    logic [15:0] pc_q;
    logic [7:0] x_q;
    logic [7:0] a_q;
    logic [7:0] ccr_q;
    logic mask_q;
    logic [4:0] vec_q;
    logic [23:0] queue_q;
    logic resume_q;
    logic [4:0] ext_ctrl_q;
    logic flag_q;
    logic pin_q;
    logic pin_prev_q;
    logic level_q;
    logic bus_wr_q;
    logic [7:0] bus_addr_q;
    logic [31:0] rdata_q;
    logic pe;
    logic asserted;
    logic flag_set;
    logic flag_clr;
    logic [31:0] req;
    logic req_any;
    logic [4:0] req_vec;
    logic take;
    logic bus_phase;
    logic [15:0] vec_addr;

    // Lowest numbered pending vector wins
    function automatic logic [4:0] pick(input logic [31:0] r);
        logic [4:0] v;
        v = isv_pkg::VEC_LAST;
        for (int i = 31; i >= 0; i--) begin
            if (r[i]) begin
                v = 5'(i);
            end
        end
        return v;
    endfunction

    // Vector n sits at base + 2*(31-n)
    function automatic logic [15:0] vaddr(input logic [4:0] v);
        return isv_pkg::VEC_BASE +
            {10'h000, isv_pkg::VEC_LAST - v, 1'b0};
    endfunction

    // Request collection from the flag/enable pairs
    always_comb begin
        req = 32'h0000_0000;
        req[isv_pkg::V_ACMP] = SRC_FLAGS[isv_pkg::S_ACMP]
            & SRC_ENABLES[isv_pkg::S_ACMP];
        req[isv_pkg::V_MTIM] = SRC_FLAGS[isv_pkg::S_MTIM]
            & SRC_ENABLES[isv_pkg::S_MTIM];
        req[isv_pkg::V_RTC] = SRC_FLAGS[isv_pkg::S_RTC]
            & SRC_ENABLES[isv_pkg::S_RTC];
        req[isv_pkg::V_IIC] = SRC_FLAGS[isv_pkg::S_IIC]
            & SRC_ENABLES[isv_pkg::S_IIC];
        req[isv_pkg::V_ADC] = SRC_FLAGS[isv_pkg::S_ADC]
            & SRC_ENABLES[isv_pkg::S_ADC];
        req[isv_pkg::V_PORTB] = SRC_FLAGS[isv_pkg::S_PORTB]
            & SRC_ENABLES[isv_pkg::S_PORTB];
        req[isv_pkg::V_PORTA] = SRC_FLAGS[isv_pkg::S_PORTA]
            & SRC_ENABLES[isv_pkg::S_PORTA];
        req[isv_pkg::V_SCI_TX] = |(SRC_FLAGS[isv_pkg::S_TX_DONE:
            isv_pkg::S_TX_EMPTY] & SRC_ENABLES[isv_pkg::S_TX_DONE:
            isv_pkg::S_TX_EMPTY]);
        req[isv_pkg::V_SCI_RX] = |(SRC_FLAGS[isv_pkg::S_RX_LAST:
            isv_pkg::S_RX_FIRST] & SRC_ENABLES[isv_pkg::S_RX_LAST:
            isv_pkg::S_RX_FIRST]);
        req[isv_pkg::V_SCI_ERR] = |(SRC_FLAGS[isv_pkg::S_ERR_LAST:
            isv_pkg::S_ERR_FIRST] & SRC_ENABLES[isv_pkg::S_ERR_LAST:
            isv_pkg::S_ERR_FIRST]);
        // Fault shares the transfer-done enable
        req[isv_pkg::V_SYNC] = ((SRC_FLAGS[isv_pkg::S_SYNC_DONE]
            | SRC_FLAGS[isv_pkg::S_SYNC_FAULT])
            & SRC_ENABLES[isv_pkg::S_SYNC_DONE])
            | (SRC_FLAGS[isv_pkg::S_SYNC_TX]
            & SRC_ENABLES[isv_pkg::S_SYNC_TX]);
        req[isv_pkg::V_EXT_REQ] = flag_q & pe
            & ext_ctrl_q[isv_pkg::B_INT_ENABLE];
    end

    assign req_any = |req;
    assign req_vec = pick(req);
    assign vec_addr = vaddr(vec_q);
    // Accept only at an instruction boundary with the mask clear
    assign take = state_q == isv_pkg::ST_IDLE && CPU_INSTR_DONE
        && !CPU_RETURN && req_any && !mask_q;

    // External request pin
    assign pe = ext_ctrl_q[isv_pkg::B_PIN_ENABLE];
    assign asserted = pin_q ~^ ext_ctrl_q[isv_pkg::B_POLARITY];
    // Edge taken from the pin itself, so in edge mode a polarity write alone never sets
    assign flag_set = pe && asserted && (pin_q != pin_prev_q
        || ext_ctrl_q[isv_pkg::B_LEVEL_MODE]);
    assign flag_clr = bus_wr_q && bus_addr_q == isv_pkg::OFS_EXT_CTRL
        && HWDATA[isv_pkg::B_FLAG];

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            pin_q <= 1'b0;
            pin_prev_q <= 1'b0;
            level_q <= 1'b0;
        end else begin
            pin_q <= EXT_REQ_PIN;
            pin_prev_q <= pin_q;
            level_q <= pe & EXT_REQ_PIN;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            flag_q <= 1'b0;
        end else if (flag_set) begin
            flag_q <= 1'b1;
        end else if (flag_clr || !pe) begin
            flag_q <= 1'b0;
        end
    end

    // Pull follows polarity: active-low input pulls up
    assign EXT_REQ_PULL_UP = pe
        && !ext_ctrl_q[isv_pkg::B_PULL_DISABLE]
        && !ext_ctrl_q[isv_pkg::B_POLARITY];
    assign EXT_REQ_PULL_DOWN = pe
        && !ext_ctrl_q[isv_pkg::B_PULL_DISABLE]
        && ext_ctrl_q[isv_pkg::B_POLARITY];
    // Unclocked path: must work while the clock is stopped
    assign EXT_REQ_WAKE = STOP_MODE && pe
        && (EXT_REQ_PIN ~^ ext_ctrl_q[isv_pkg::B_POLARITY]);
    assign EXT_REQ_LEVEL = level_q;

    // Bus slave: zero wait, read data captured in address phase
    assign bus_phase = HSEL && HTRANS[1] && HREADY;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = rdata_q;

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            bus_wr_q <= 1'b0;
            bus_addr_q <= 8'h00;
            rdata_q <= 32'h0000_0000;
        end else begin
            bus_wr_q <= bus_phase && HWRITE;
            bus_addr_q <= HADDR[7:0];
            rdata_q <= 32'h0000_0000;
            if (bus_phase && !HWRITE && HADDR[31:8] == 24'h000000) begin
                case (HADDR[7:0])
                    isv_pkg::OFS_EXT_CTRL: rdata_q <=
                        {25'h0000000, level_q, flag_q, ext_ctrl_q};
                    isv_pkg::OFS_MASK: rdata_q <= {31'h00000000, mask_q};
                    isv_pkg::OFS_STATUS: rdata_q <= {22'h000000,
                        state_q != isv_pkg::ST_IDLE, req_any, 3'h0,
                        req_vec};
                    isv_pkg::OFS_STACK_PTR: rdata_q <= {16'h0000, sp_q};
                    isv_pkg::OFS_PC_VIEW: rdata_q <= {16'h0000, pc_q};
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ext_ctrl_q <= isv_pkg::EXT_CTRL_RESET;
        end else if (bus_wr_q && bus_addr_q == isv_pkg::OFS_EXT_CTRL) begin
            ext_ctrl_q <= HWDATA[4:0];
        end
    end

    // Global mask: set by reset and by entry, restored on return
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            mask_q <= 1'b1;
        end else if (state_q == isv_pkg::ST_PUSH
            && cnt_q == isv_pkg::FRAME_BYTES - 3'd1) begin
            mask_q <= 1'b1;
        end else if (state_q == isv_pkg::ST_POP && cnt_q == 3'd1) begin
            mask_q <= MEM_RDATA[isv_pkg::B_CCR_MASK];
        end else if (bus_wr_q && bus_addr_q == isv_pkg::OFS_MASK) begin
            mask_q <= HWDATA[0];
        end
    end

    // Stack frame and return sequencer
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state_q <= isv_pkg::ST_IDLE;
            cnt_q <= 3'd0;
        end else begin
            case (state_q)
                isv_pkg::ST_IDLE: begin
                    cnt_q <= 3'd0;
                    if (CPU_INSTR_DONE && CPU_RETURN) begin
                        state_q <= isv_pkg::ST_POP;
                    end else if (take) begin
                        state_q <= isv_pkg::ST_PUSH;
                    end
                end
                isv_pkg::ST_PUSH: begin
                    cnt_q <= cnt_q + 3'd1;
                    if (cnt_q == isv_pkg::FRAME_BYTES - 3'd1) begin
                        state_q <= isv_pkg::ST_VEC;
                        cnt_q <= 3'd0;
                    end
                end
                isv_pkg::ST_VEC: begin
                    cnt_q <= cnt_q + 3'd1;
                    if (cnt_q == 3'd2) begin
                        state_q <= isv_pkg::ST_FETCH;
                        cnt_q <= 3'd0;
                    end
                end
                isv_pkg::ST_FETCH: begin
                    cnt_q <= cnt_q + 3'd1;
                    if (cnt_q == isv_pkg::QUEUE_BYTES) begin
                        state_q <= isv_pkg::ST_IDLE;
                        cnt_q <= 3'd0;
                    end
                end
                isv_pkg::ST_POP: begin
                    cnt_q <= cnt_q + 3'd1;
                    if (cnt_q == isv_pkg::FRAME_BYTES) begin
                        state_q <= isv_pkg::ST_FETCH;
                        cnt_q <= 3'd0;
                    end
                end
                default: begin
                    state_q <= isv_pkg::ST_IDLE;
                    cnt_q <= 3'd0;
                end
            endcase
        end
    end

    // Register snapshot, vector capture and pops
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            pc_q <= 16'h0000;
            x_q <= 8'h00;
            a_q <= 8'h00;
            ccr_q <= 8'h00;
            vec_q <= isv_pkg::VEC_LAST;
            queue_q <= 24'h000000;
        end else begin
            if (take) begin
                pc_q <= CPU_PC_NEXT;
                x_q <= CPU_X;
                a_q <= CPU_A;
                ccr_q <= CPU_CCR;
                ccr_q[isv_pkg::B_CCR_MASK] <= mask_q;
            end
            // Latest winner is sampled right before the vector read
            if (state_q == isv_pkg::ST_PUSH
                && cnt_q == isv_pkg::FRAME_BYTES - 3'd1) begin
                vec_q <= req_vec;
            end
            if (state_q == isv_pkg::ST_VEC && cnt_q == 3'd1) begin
                pc_q[15:8] <= MEM_RDATA;
            end
            if (state_q == isv_pkg::ST_VEC && cnt_q == 3'd2) begin
                pc_q[7:0] <= MEM_RDATA;
            end
            if (state_q == isv_pkg::ST_FETCH && cnt_q != 3'd0) begin
                queue_q <= {queue_q[15:0], MEM_RDATA};
            end
            if (state_q == isv_pkg::ST_POP) begin
                case (cnt_q)
                    3'd1: ccr_q <= MEM_RDATA;
                    3'd2: a_q <= MEM_RDATA;
                    3'd3: x_q <= MEM_RDATA;
                    3'd4: pc_q[15:8] <= MEM_RDATA;
                    3'd5: pc_q[7:0] <= MEM_RDATA;
                    default: pc_q <= pc_q;
                endcase
            end
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            sp_q <= isv_pkg::SP_RESET;
        end else if (state_q == isv_pkg::ST_PUSH
            && cnt_q == isv_pkg::FRAME_BYTES - 3'd1) begin
            sp_q <= sp_q - 16'd5;
        end else if (state_q == isv_pkg::ST_POP
            && cnt_q == isv_pkg::FRAME_BYTES) begin
            sp_q <= sp_q + 16'd5;
        end else if (bus_wr_q && bus_addr_q == isv_pkg::OFS_STACK_PTR) begin
            sp_q <= HWDATA[15:0];
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            resume_q <= 1'b0;
        end else begin
            resume_q <= state_q == isv_pkg::ST_FETCH
                && cnt_q == isv_pkg::QUEUE_BYTES;
        end
    end

    // Memory port, driven straight from sequencer state
    always_comb begin
        MEM_ADDR = 16'h0000;
        MEM_WDATA = 8'h00;
        MEM_WE = 1'b0;
        MEM_RE = 1'b0;
        case (state_q)
            isv_pkg::ST_PUSH: begin
                MEM_WE = 1'b1;
                MEM_ADDR = sp_q - {13'h0000, cnt_q};
                case (cnt_q)
                    3'd0: MEM_WDATA = pc_q[7:0];
                    3'd1: MEM_WDATA = pc_q[15:8];
                    3'd2: MEM_WDATA = x_q;
                    3'd3: MEM_WDATA = a_q;
                    default: MEM_WDATA = ccr_q;
                endcase
            end
            isv_pkg::ST_VEC: begin
                MEM_RE = cnt_q != 3'd2;
                MEM_ADDR = vec_addr + {15'h0000, cnt_q[0]};
            end
            isv_pkg::ST_FETCH: begin
                MEM_RE = cnt_q != isv_pkg::QUEUE_BYTES;
                MEM_ADDR = pc_q + {13'h0000, cnt_q};
            end
            isv_pkg::ST_POP: begin
                MEM_RE = cnt_q != isv_pkg::FRAME_BYTES;
                MEM_ADDR = sp_q + {13'h0000, cnt_q} + 16'd1;
            end
            default: MEM_ADDR = 16'h0000;
        endcase
    end

    assign CPU_PC_OUT = pc_q;
    assign CPU_X_OUT = x_q;
    assign CPU_A_OUT = a_q;
    assign CPU_CCR_OUT = {ccr_q[7:4], mask_q, ccr_q[2:0]};
    assign CPU_QUEUE = queue_q;
    assign CPU_RESUME = resume_q;
    assign CPU_BUSY = state_q != isv_pkg::ST_IDLE;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    a_push_first_low: assert property (
        state_q == isv_pkg::ST_IDLE && take |=> MEM_WE
        && MEM_WDATA == $past(CPU_PC_NEXT[7:0]) && MEM_ADDR == sp_q)
        else $error("first pushed byte is not pc low");
    a_push_ccr_last: assert property (
        take ##1 MEM_WE [*4] ##1 MEM_WE |-> MEM_WDATA == ccr_q)
        else $error("last pushed byte is not ccr");
    a_sp_below_ccr: assert property (
        state_q == isv_pkg::ST_PUSH && cnt_q == 3'd4
        |=> sp_q == $past(MEM_ADDR) - 16'd1)
        else $error("stack pointer not below ccr");
    a_mask_on_entry: assert property (
        take |-> ##6 mask_q ##0 state_q == isv_pkg::ST_VEC)
        else $error("mask not set after stacking");
    a_masked_no_take: assert property (
        mask_q && state_q == isv_pkg::ST_IDLE && !CPU_RETURN
        |=> state_q != isv_pkg::ST_PUSH)
        else $error("request taken while masked");
    a_vec_hi_addr: assert property (
        state_q == isv_pkg::ST_VEC && cnt_q == 3'd0
        |-> MEM_ADDR == vaddr(vec_q) && MEM_RE)
        else $error("vector high byte address wrong");
    a_level_holds: assert property (
        pe && ext_ctrl_q[isv_pkg::B_LEVEL_MODE] && asserted |=> flag_q)
        else $error("level mode flag dropped");
    a_pull_off: assert property (
        ext_ctrl_q[isv_pkg::B_PULL_DISABLE] || !pe
        |-> !EXT_REQ_PULL_UP && !EXT_REQ_PULL_DOWN)
        else $error("pull active while disabled");
    a_return_fetch: assert property (
        state_q == isv_pkg::ST_POP && cnt_q == 3'd5
        |=> state_q == isv_pkg::ST_FETCH ##4 resume_q)
        else $error("return did not refill queue");
    c_entry: cover property (take ##[1:20] resume_q);
    c_return: cover property (state_q == isv_pkg::ST_POP ##[1:20] resume_q);
    c_ext_req: cover property (flag_set ##1 req[isv_pkg::V_EXT_REQ]);
endmodule
`default_nettype wire

// [bench/isv_pin_src.sv]
// Behavioural source driving the external request pin
`default_nettype none
module isv_pin_src (
    input wire logic clk,
    input wire logic drive_en,
    input wire logic drive_val,
    input wire logic pull_up,
    input wire logic pull_down,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_q = 1'b0;
    always_ff @(posedge clk) begin
        if (drive_en) begin
            last_q <= drive_val;
        end
    end
    // Released with no pull: show the inverse so a stale level never passes
    always_comb begin
        if (drive_en) begin
            pin = drive_val;
        end else if (pull_up) begin
            pin = 1'b1;
        end else if (pull_down) begin
            pin = 1'b0;
        end else begin
            pin = ~last_q;
        end
    end
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench for the interrupt vector and stacking block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, hsel = 0, hwrite = 0, stop = 0;
    logic drv_en = 0, drv_val = 0, idone = 0, iret = 0;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [19:0] flags = 0, enables = 0;
    logic [15:0] pc_next = 0, pc_out, maddr;
    logic [7:0] cx = 0, ca = 0, cc = 0, x_out, a_out, cc_out, mwd, mrd = 0;
    logic [23:0] queue;
    logic hready, hresp, pin, pu, pd, wake, lvl, mwe, mre, resume, busy;
    logic [7:0] mem [0:65535];
    logic [15:0] wa[$], ra[$];
    logic [7:0] wdq[$];
    int err_total = 0, checked = 0;
    always #10 clk = ~clk;
    isv_core u_dut (.SYS_CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hready), .HREADYOUT(hready), .HRESP(hresp), .HRDATA(hrdata),
        .EXT_REQ_PIN(pin), .STOP_MODE(stop), .EXT_REQ_PULL_UP(pu),
        .EXT_REQ_PULL_DOWN(pd), .EXT_REQ_WAKE(wake), .EXT_REQ_LEVEL(lvl),
        .SRC_FLAGS(flags), .SRC_ENABLES(enables), .CPU_INSTR_DONE(idone),
        .CPU_RETURN(iret), .CPU_PC_NEXT(pc_next), .CPU_X(cx), .CPU_A(ca),
        .CPU_CCR(cc), .MEM_ADDR(maddr), .MEM_WDATA(mwd), .MEM_WE(mwe),
        .MEM_RE(mre), .MEM_RDATA(mrd), .CPU_PC_OUT(pc_out),
        .CPU_X_OUT(x_out), .CPU_A_OUT(a_out), .CPU_CCR_OUT(cc_out),
        .CPU_QUEUE(queue), .CPU_RESUME(resume), .CPU_BUSY(busy));
    isv_pin_src u_src (.clk(clk), .drive_en(drv_en), .drive_val(drv_val),
        .pull_up(pu), .pull_down(pd), .pin(pin));
    // Memory answers one cycle after the address, as the sequencer expects
    always @(posedge clk) begin
        if (mwe === 1'b1) begin
            mem[maddr] <= mwd;
            wa.push_back(maddr);
            wdq.push_back(mwd);
        end
        if (mre === 1'b1) begin
            ra.push_back(maddr);
        end
        mrd <= mem[maddr];
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    task wait_resume;
        for (int i = 0; i < 60 && resume !== 1'b1; i++) @(posedge clk);
        chk(resume, 1);
    endtask
    task t_pin;
        bus(1, 8'h00, 32'h07);
        drv_en <= 1;
        drv_val <= 1;
        tick(4);
        chk(pd, 1);
        chk(pu, 0);
        chk(lvl, 1);
        bus(1, 8'h00, 32'h27);
        bus(0, 8'h00, 0);
        chk(rd[5], 1);
        stop <= 1;
        tick(2);
        chk(wake, 1);
        stop <= 0;
        drv_val <= 0;
        tick(4);
        bus(1, 8'h00, 32'h27);
        bus(0, 8'h00, 0);
        chk(rd[5], 0);
        bus(1, 8'h00, 32'h17);
        tick(2);
        chk({pu, pd}, 0);
        bus(1, 8'h00, 32'h00);
        drv_val <= 1;
        tick(4);
        chk(lvl, 0);
        drv_en <= 0;
    endtask
    task t_entry;
        bus(1, 8'h04, 0);
        // Port A flag set but not enabled: would win if gating were lost
        flags <= 20'h49;
        enables <= 20'h09;
        pc_next <= 16'h1234;
        cx <= 8'h56;
        ca <= 8'h78;
        cc <= 8'h60;
        idone <= 1;
        @(posedge clk);
        idone <= 0;
        wait_resume();
        chk(wa.size(), 5);
        for (int i = 0; i < 5; i++) begin
            chk(wa[i], 16'h00ff - i);
            chk(wdq[i], 8'(40'h3412567860 >> (32 - 8 * i)));
        end
        chk(ra[0], 16'hffce);
        chk(ra[1], 16'hffcf);
        chk(queue, 24'ha1b2c3);
        flags <= 0;
        bus(0, 8'h0c, 0);
        chk(rd[15:0], 16'h00fa);
        bus(0, 8'h04, 0);
        chk(rd[0], 1);
    endtask
    task t_return;
        ra.delete();
        idone <= 1;
        iret <= 1;
        @(posedge clk);
        idone <= 0;
        iret <= 0;
        wait_resume();
        chk(ra[0], 16'h00fb);
        chk(pc_out, 16'h1234);
        chk({a_out, x_out, cc_out}, 24'h785660);
        chk(queue, 24'hd4e5f6);
        bus(0, 8'h0c, 0);
        chk(rd[15:0], 16'h00ff);
    endtask
    // Falling edge on an active-low pin, edge-only, interrupt enabled
    task t_ext;
        ra.delete();
        drv_en <= 1;
        drv_val <= 1;
        bus(1, 8'h00, 32'h09);
        tick(2);
        chk(pu, 1);
        drv_val <= 0;
        tick(3);
        bus(0, 8'h08, 0);
        chk(rd[9:0], 10'h102);
        idone <= 1;
        @(posedge clk);
        idone <= 0;
        wait_resume();
        chk(ra[0], 16'hfffa);
        chk(pc_out, 16'h9000);
        // Mask is set again while the pin flag still requests
        idone <= 1;
        @(posedge clk);
        idone <= 0;
        @(posedge clk);
        chk(busy, 0);
        bus(1, 8'h00, 32'h29);
        bus(0, 8'h00, 0);
        chk(rd[5], 0);
    endtask
    task tally_and_finish;
        $display("errors %0d checks %0d", err_total, checked);
        if (err_total == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        {mem[16'hffce], mem[16'hffcf]} = 16'h8000;
        {mem[16'hfffa], mem[16'hfffb]} = 16'h9000;
        {mem[16'h8000], mem[16'h8001], mem[16'h8002]} = 24'ha1b2c3;
        {mem[16'h1234], mem[16'h1235], mem[16'h1236]} = 24'hd4e5f6;
        repeat (8) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        bus(0, 8'h04, 0);
        chk(rd[0], 1);
        t_pin();
        t_entry();
        t_return();
        t_ext();
        tally_and_finish();
    end
    // Whole run needs about a hundred cycles; cut off a hang well beyond that
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
